// ### inc/imcl_pkg.sv
// Package with constants, types and register map of the interference monitor and lock block.
package imcl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] IMCL_OFS_CTRL = 8'h00;
  localparam logic [7:0] IMCL_OFS_THRESH = 8'h04;
  localparam logic [7:0] IMCL_OFS_LOCK = 8'h08;
  localparam logic [7:0] IMCL_OFS_STATE = 8'h0c;
  localparam logic [7:0] IMCL_OFS_JAM = 8'h10;
  localparam logic [7:0] IMCL_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] IMCL_OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] IMCL_OFS_REF = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int IMCL_CTRL_EN_BIT = 0;
  localparam int IMCL_CTRL_ANT_BIT = 1;
  localparam int IMCL_LOCK_RAM_BIT = 0;
  localparam int IMCL_LOCK_STORE_BIT = 1;
  localparam int IMCL_LOCK_CLR_BIT = 2;
  localparam int IMCL_THR_BB_LSB = 0;
  localparam int IMCL_THR_NB_LSB = 8;
  localparam logic [7:0] IMCL_BB_THR_RST = 8'h03;
  localparam logic [7:0] IMCL_NB_THR_RST = 8'h0f;
  localparam logic [7:0] IMCL_CN0_DROP_RST = 8'h06;
  localparam int IMCL_IRQ_W = 4;
  localparam int IMCL_IRQ_STATE_BIT = 0;
  localparam int IMCL_IRQ_SPOOF_BIT = 1;
  localparam int IMCL_IRQ_REJECT_BIT = 2;
  localparam int IMCL_IRQ_REF_BIT = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    IMCL_ST_UNKNOWN = 2'h0,
    IMCL_ST_OK = 2'h1,
    IMCL_ST_WARNING = 2'h2,
    IMCL_ST_CRITICAL = 2'h3
  } imcl_state_t;

  // Reference capture sequence, Gray coded along the usual path.
  typedef enum logic [1:0]
  {
    IMCL_REF_WAIT = 2'h0,
    IMCL_REF_CAPTURE = 2'h1,
    IMCL_REF_VALID = 2'h3
  } imcl_ref_t;

  // One spectrum sample from the front end, in dB.
  typedef struct packed
  {
    logic valid;
    logic [7:0] broadband_db;
    logic [7:0] peak_db;
    logic [7:0] cn0_db;
  } imcl_spectrum_t;

  // Navigation and antenna status levels.
  typedef struct packed
  {
    logic fix_good;
    logic pos_valid;
    logic ant_connected;
    logic genuine;
    logic counterfeit;
  } imcl_nav_t;

  typedef struct packed
  {
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic monitor_enable;
    logic antenna_type;
    logic [7:0] broadband_threshold;
    logic [7:0] narrowband_threshold;
    logic lock_ram;
    logic lock_store;
    logic lock_any;
    imcl_ref_t ref_state;
    logic [7:0] ref_bb;
    logic [7:0] ref_peak;
    logic [7:0] ref_cn0;
    logic [7:0] base_jam;
    logic base_valid;
    logic [7:0] narrowband_jam_level;
    imcl_state_t interference_state;
    logic was_genuine;
    logic spoof_flag;
    logic [IMCL_IRQ_W-1:0] irq_stat;
    logic [IMCL_IRQ_W-1:0] irq_mask;
    logic cfg_reject;
  } imcl_regs_t;

endpackage

// ### rtl/imcl_monitor.sv
// Interference monitor, jamming indicator, spoofing flag and config lock behind Wishbone.
`timescale 1ns/1ps

// Behaviour
// - Narrow-band jam level always runs, reported relative to unjammed baseline.
// - Monitor is off after reset; writing one to its enable turns it on.
// - Broadband excess over reference beyond broadband threshold flags interference.
// - Spectral peak over reference beyond narrow-band threshold flags interference.
// - Reference captured once after start-up after good fix; unknown until then.
// - With reference, each new spectrum is compared using both thresholds.
// - State 0 when disabled, uninitialised or antenna disconnected.
// - State 1 when active with reference and no threshold exceeded.
// - State 2 when interference seen and position still valid.
// - State 3 when interference seen and no reliable position.
// - Drop in average carrier-to-noise also counts as interference.
// - When locked, control, threshold and lock writes are refused; a lock write with its clear bit set still passes, as do interrupt mask writes.
// - Battery-backed lock survives resets until that store is cleared.
// - RAM-layer lock is lost at reset, leaving configuration unlocked unless the battery-backed lock is restored.
// - Spoofing flagged only on genuine to counterfeit transition.
module imcl_monitor
  import imcl_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic store_clear_in,
  input wire logic [1:0] store_lock_restore_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire imcl_spectrum_t spectrum_in,
  input wire logic [7:0] cw_level_in,
  input wire imcl_nav_t nav_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic irq_out,
  output logic [1:0] interference_state_out,
  output logic [7:0] narrowband_jam_level_out,
  output logic spoof_detect_out,
  output logic config_write_lock_out,
  output logic lock_store_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Saturating difference a - b, zero when b is above a.
  function automatic logic [7:0] imcl_excess(input logic [7:0] a, input logic [7:0] b);
    imcl_excess = (a > b) ? (a - b) : 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers for front-end and navigation levels
  // ----------------------------------------------------------------
  // The status levels come from another part of the chip on unknown timing, so
  // they pass two flops; the spectrum word is qualified by its synced valid.
  imcl_nav_t nav_s1_reg;
  imcl_nav_t nav_s2_reg;
  logic store_clr_s1_reg;
  logic store_clr_s2_reg;
  logic [1:0] restore_s1_reg;
  logic [1:0] restore_s2_reg;
  logic spec_v_s1_reg;
  logic spec_v_s2_reg;
  logic spec_v_s3_reg;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      nav_s1_reg <= '0;
      nav_s2_reg <= '0;
      store_clr_s1_reg <= 1'b0;
      store_clr_s2_reg <= 1'b0;
      spec_v_s1_reg <= 1'b0;
      spec_v_s2_reg <= 1'b0;
      spec_v_s3_reg <= 1'b0;
    end
    else
    begin
      nav_s1_reg <= nav_in;
      nav_s2_reg <= nav_s1_reg;
      store_clr_s1_reg <= store_clear_in;
      store_clr_s2_reg <= store_clr_s1_reg;
      spec_v_s1_reg <= spectrum_in.valid;
      spec_v_s2_reg <= spec_v_s1_reg;
      spec_v_s3_reg <= spec_v_s2_reg;
    end
  end

  // The stored-lock level is synced without reset on purpose: the clock runs during
  // reset, so the value is settled by the first edge after release.
  always_ff @(posedge clk_in)
  begin
    restore_s1_reg <= store_lock_restore_in;
    restore_s2_reg <= restore_s1_reg;
  end

  // A rising synced valid marks a new sample; the data is held stable by the source.
  logic spec_new;
  assign spec_new = spec_v_s2_reg && !spec_v_s3_reg;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  imcl_regs_t s_reg;
  imcl_regs_t s_next;
  logic restore_done_reg;

  logic bus_req;
  logic wr;
  logic locked;
  logic cfg_addr;
  logic [31:0] rd_data;
  logic over_bb;
  logic over_nb;
  logic cn0_drop;
  logic interf;
  imcl_state_t st_calc;
  logic [IMCL_IRQ_W-1:0] ev;

  always_comb
  begin
    s_next = s_reg;
    bus_req = wb_cyc_in && wb_stb_in && !s_reg.ack;
    wr = bus_req && wb_we_in;
    locked = s_reg.lock_any;
    cfg_addr = (wb_adr_in == IMCL_OFS_CTRL) || (wb_adr_in == IMCL_OFS_THRESH)
               || (wb_adr_in == IMCL_OFS_LOCK && !wb_dat_in[IMCL_LOCK_CLR_BIT]);
    ev = '0;

    // Single-cycle answer; ack drops the cycle after it was given.
    s_next.ack = bus_req;

    // Read mux.
    unique case (wb_adr_in)
      IMCL_OFS_CTRL: rd_data = {30'h0, s_reg.antenna_type, s_reg.monitor_enable};
      IMCL_OFS_THRESH: rd_data = {16'h0, s_reg.narrowband_threshold, s_reg.broadband_threshold};
      IMCL_OFS_LOCK: rd_data = {29'h0, s_reg.cfg_reject, s_reg.lock_store, s_reg.lock_ram};
      IMCL_OFS_STATE: rd_data = {29'h0, s_reg.spoof_flag, s_reg.interference_state};
      IMCL_OFS_JAM: rd_data = {24'h0, s_reg.narrowband_jam_level};
      IMCL_OFS_IRQ_STAT: rd_data = {28'h0, s_reg.irq_stat};
      IMCL_OFS_IRQ_MASK: rd_data = {28'h0, s_reg.irq_mask};
      IMCL_OFS_REF: rd_data = {6'h0, s_reg.ref_state, s_reg.ref_cn0, s_reg.ref_peak, s_reg.ref_bb};
      default: rd_data = 32'h0;
    endcase
    s_next.dat = (bus_req && !wb_we_in) ? rd_data : 32'h0;

    // Configuration writes, refused while locked.
    s_next.cfg_reject = 1'b0;
    if (wr && cfg_addr && locked)
    begin
      s_next.cfg_reject = 1'b1;
      ev[IMCL_IRQ_REJECT_BIT] = 1'b1;
    end
    else if (wr)
    begin
      if (wb_adr_in == IMCL_OFS_CTRL && wb_sel_in[0])
      begin
        s_next.monitor_enable = wb_dat_in[IMCL_CTRL_EN_BIT];
        s_next.antenna_type = wb_dat_in[IMCL_CTRL_ANT_BIT];
      end
      if (wb_adr_in == IMCL_OFS_THRESH)
      begin
        if (wb_sel_in[0])
          s_next.broadband_threshold = wb_dat_in[IMCL_THR_BB_LSB +: 8];
        if (wb_sel_in[1])
          s_next.narrowband_threshold = wb_dat_in[IMCL_THR_NB_LSB +: 8];
      end
      if (wb_adr_in == IMCL_OFS_LOCK && wb_sel_in[0])
      begin
        // Setting either layer locks; a lock can only be raised here.
        if (wb_dat_in[IMCL_LOCK_RAM_BIT])
          s_next.lock_ram = 1'b1;
        if (wb_dat_in[IMCL_LOCK_STORE_BIT])
          s_next.lock_store = 1'b1;
      end
      if (wb_adr_in == IMCL_OFS_IRQ_MASK && wb_sel_in[0])
        s_next.irq_mask = wb_dat_in[IMCL_IRQ_W-1:0];
    end

    // Clearing the battery-backed store is the only way out of a persistent lock.
    if (store_clr_s2_reg)
      s_next.lock_store = 1'b0;
    if (!restore_done_reg)
      s_next.lock_store = restore_s2_reg[IMCL_LOCK_STORE_BIT] && !store_clr_s2_reg;
    s_next.lock_any = s_next.lock_ram || s_next.lock_store;

    // Jamming indicator: baseline is the first sample, level is rise above it.
    if (spec_new)
    begin
      if (!s_reg.base_valid)
      begin
        s_next.base_jam = cw_level_in;
        s_next.base_valid = 1'b1;
      end
      // The first sample is its own baseline, so it reports zero, not its raw level.
      s_next.narrowband_jam_level =
        imcl_excess(cw_level_in, s_reg.base_valid ? s_reg.base_jam : cw_level_in);
    end

    // Reference capture, once per start-up.
    unique case (s_reg.ref_state)
      IMCL_REF_WAIT:
        if (nav_s2_reg.fix_good)
          s_next.ref_state = IMCL_REF_CAPTURE;
      IMCL_REF_CAPTURE:
        if (spec_new)
        begin
          s_next.ref_bb = spectrum_in.broadband_db;
          s_next.ref_peak = spectrum_in.peak_db;
          s_next.ref_cn0 = spectrum_in.cn0_db;
          s_next.ref_state = IMCL_REF_VALID;
          ev[IMCL_IRQ_REF_BIT] = 1'b1;
        end
      IMCL_REF_VALID:
        s_next.ref_state = IMCL_REF_VALID;
      default:
        s_next.ref_state = IMCL_REF_WAIT;
    endcase

    // Comparison against the stored reference.
    over_bb = imcl_excess(spectrum_in.broadband_db, s_reg.ref_bb)
              > s_reg.broadband_threshold;
    over_nb = imcl_excess(spectrum_in.peak_db, s_reg.ref_peak)
              > s_reg.narrowband_threshold;
    cn0_drop = imcl_excess(s_reg.ref_cn0, spectrum_in.cn0_db) > IMCL_CN0_DROP_RST;
    interf = over_bb || over_nb || cn0_drop;
    if (!interf)
      st_calc = IMCL_ST_OK;
    else if (nav_s2_reg.pos_valid)
      st_calc = IMCL_ST_WARNING;
    else
      st_calc = IMCL_ST_CRITICAL;

    if (!s_reg.monitor_enable || s_reg.ref_state != IMCL_REF_VALID
        || !nav_s2_reg.ant_connected)
      s_next.interference_state = IMCL_ST_UNKNOWN;
    else if (spec_new)
      s_next.interference_state = st_calc;
    if (s_next.interference_state != s_reg.interference_state)
      ev[IMCL_IRQ_STATE_BIT] = 1'b1;

    // Spoofing only after the signal was seen genuine.
    if (nav_s2_reg.genuine && !nav_s2_reg.counterfeit)
      s_next.was_genuine = 1'b1;
    if (s_reg.was_genuine && nav_s2_reg.counterfeit && !s_reg.spoof_flag)
    begin
      s_next.spoof_flag = 1'b1;
      ev[IMCL_IRQ_SPOOF_BIT] = 1'b1;
    end

    // Write-one-to-clear; a new event in the same cycle wins.
    if (wr && wb_adr_in == IMCL_OFS_IRQ_STAT && wb_sel_in[0])
      s_next.irq_stat = s_reg.irq_stat & ~wb_dat_in[IMCL_IRQ_W-1:0];
    s_next.irq_stat = s_next.irq_stat | ev;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
  end

  // The RAM-layer lock and all settings return to default on reset.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_reg <= '0;
      s_reg.broadband_threshold <= IMCL_BB_THR_RST;
      s_reg.narrowband_threshold <= IMCL_NB_THR_RST;
      s_reg.ref_state <= IMCL_REF_WAIT;
      s_reg.interference_state <= IMCL_ST_UNKNOWN;
      restore_done_reg <= 1'b0;
    end
    else
    begin
      s_reg <= s_next;
      restore_done_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_dat_out = s_reg.dat;
  assign wb_ack_out = s_reg.ack;
  assign irq_out = s_reg.irq;
  assign interference_state_out = s_reg.interference_state;
  assign narrowband_jam_level_out = s_reg.narrowband_jam_level;
  assign spoof_detect_out = s_reg.spoof_flag;
  assign config_write_lock_out = s_reg.lock_any;
  assign lock_store_out = s_reg.lock_store;

endmodule

// ### test/imcl_frontend_model.sv
// Model of the front end feeding spectrum samples and navigation status.
`timescale 1ns/1ps
module imcl_frontend_model
  import imcl_pkg::*;
(
  input wire logic clk_in,
  output imcl_spectrum_t spectrum_out,
  output logic [7:0] cw_level_out,
  output imcl_nav_t nav_out
);
  initial
  begin
    spectrum_out = '0;
    cw_level_out = 8'h00;
    nav_out = '0;
  end
  task automatic sample(input logic [7:0] bb, input logic [7:0] pk, input logic [7:0] cn,
    input logic [7:0] cw);
    @(posedge clk_in);
    spectrum_out <= '{1'b1, bb, pk, cn};
    cw_level_out <= cw;
    repeat (6) @(posedge clk_in);
    // Once the hold time is over the data lines show garbage, not the old sample.
    spectrum_out <= '{1'b0, ~bb, ~pk, ~cn};
    cw_level_out <= ~cw;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic set_nav(input imcl_nav_t n);
    @(posedge clk_in);
    nav_out <= n;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

// ### test/imcl_monitor_checker.sv
// Concurrent assertions on the ports of the interference monitor block.
`timescale 1ns/1ps
module imcl_monitor_checker
  import imcl_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic store_clear_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire imcl_nav_t nav_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic [1:0] interference_state_out,
  input wire logic spoof_detect_out,
  input wire logic config_write_lock_out,
  input wire logic lock_store_out
);
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_take;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  // The clear input passes two sync flops, so it must be held three edges.
  sequence s_clear_held;
    store_clear_in [*3];
  endsequence
  sequence s_ant_off;
    !nav_in.ant_connected [*5];
  endsequence
  chk_ack_answer: assert property (s_take |=> wb_ack_out)
    else $error("request not answered next cycle");
  chk_ack_once: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  chk_ack_unasked: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  chk_lock_covers: assert property (lock_store_out |-> config_write_lock_out)
    else $error("stored lock not in force");
  chk_spoof_sticky: assert property (spoof_detect_out |=> spoof_detect_out)
    else $error("spoof flag dropped");
  chk_clear_unlocks: assert property (s_clear_held |=> !lock_store_out)
    else $error("cleared store kept lock");
  chk_ant_unknown: assert property (s_ant_off |-> interference_state_out == 2'h0)
    else $error("state not unknown with antenna off");
endmodule

bind imcl_monitor imcl_monitor_checker u_imcl_monitor_checker (.clk_in, .resetn_in,
  .store_clear_in, .wb_cyc_in, .wb_stb_in, .nav_in, .wb_dat_out, .wb_ack_out,
  .interference_state_out, .spoof_detect_out, .config_write_lock_out, .lock_store_out);

// ### test/imcl_monitor_tb.sv
// Self-checking testbench of the interference monitor and configuration lock.
`timescale 1ns/1ps
module imcl_monitor_tb
  import imcl_pkg::*;
;
  logic clk_in, resetn_in, store_clear_in, wb_cyc_in, wb_stb_in, wb_we_in;
  logic [1:0] store_lock_restore_in;
  logic [7:0] wb_adr_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, q;
  imcl_spectrum_t spectrum;
  imcl_nav_t nav;
  logic [7:0] cw_level, narrowband_jam_level_out;
  logic wb_ack_out, irq_out, spoof_detect_out, config_write_lock_out, lock_store_out;
  logic [1:0] interference_state_out;
  int mismatches, checks;
  imcl_monitor u_imcl_monitor (.clk_in, .resetn_in, .store_clear_in, .store_lock_restore_in,
    .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
    .spectrum_in(spectrum), .cw_level_in(cw_level), .nav_in(nav), .wb_dat_out, .wb_ack_out,
    .irq_out, .interference_state_out, .narrowband_jam_level_out, .spoof_detect_out,
    .config_write_lock_out, .lock_store_out);
  imcl_frontend_model u_fe (.clk_in, .spectrum_out(spectrum), .cw_level_out(cw_level),
    .nav_out(nav));
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // The master waits for ack however long it takes; only the watchdog ends a hang.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do
      @(posedge clk_in);
    while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  task automatic st(input logic [1:0] exp);
    wb(1'b0, IMCL_OFS_STATE, 32'h0);
    chk("state", q & 32'h3, {30'h0, exp});
    chk("state_out", {30'h0, interference_state_out}, {30'h0, exp});
  endtask
  task automatic rst(input logic [1:0] r);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    store_lock_restore_in <= r;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask
  initial
  begin
    #50000;
    mismatches++;
    give_verdict();
  end
  initial
  begin
    {resetn_in, store_clear_in, wb_cyc_in, wb_stb_in, wb_we_in} = 5'h00;
    store_lock_restore_in = 2'h0;
    wb_adr_in = 8'h00;
    wb_sel_in = 4'hf;
    wb_dat_in = 32'h0;
    mismatches = 0;
    checks = 0;
    rst(2'h0);
    wb(1'b0, IMCL_OFS_CTRL, 32'h0);
    chk("ctrl", q, 32'h0);
    st(2'h0);
    wb(1'b1, IMCL_OFS_CTRL, 32'h3);
    wb(1'b0, IMCL_OFS_CTRL, 32'h0);
    chk("ctrl", q, 32'h3);
    u_fe.set_nav(5'b11110);
    u_fe.sample(8'h28, 8'h28, 8'h28, 8'h0a);
    wb(1'b0, IMCL_OFS_REF, 32'h0);
    chk("ref", q & 32'h03ffffff, 32'h03282828);
    chk("jam", {24'h0, narrowband_jam_level_out}, 32'h0);
    // Each excess sits exactly on its threshold, which must not count.
    u_fe.sample(8'h2b, 8'h37, 8'h22, 8'h19);
    st(2'h1);
    chk("jam", {24'h0, narrowband_jam_level_out}, 32'hf);
    u_fe.sample(8'h2c, 8'h37, 8'h22, 8'h19);
    st(2'h2);
    u_fe.sample(8'h28, 8'h38, 8'h28, 8'h19);
    st(2'h2);
    u_fe.set_nav(5'b10110);
    u_fe.sample(8'h28, 8'h38, 8'h28, 8'h19);
    st(2'h3);
    u_fe.set_nav(5'b11110);
    u_fe.sample(8'h28, 8'h28, 8'h21, 8'h19);
    st(2'h2);
    wb(1'b0, IMCL_OFS_IRQ_STAT, 32'h0);
    chk("irq_stat", q & 32'h9, 32'h9);
    wb(1'b1, IMCL_OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_in);
    chk("irq", {31'h0, irq_out}, 32'h1);
    wb(1'b1, IMCL_OFS_IRQ_STAT, 32'hf);
    repeat (2) @(posedge clk_in);
    chk("irq", {31'h0, irq_out}, 32'h0);
    u_fe.set_nav(5'b11101);
    chk("spoof", {31'h0, spoof_detect_out}, 32'h1);
    u_fe.set_nav(5'b11001);
    st(2'h0);
    wb(1'b1, IMCL_OFS_LOCK, 32'h1);
    chk("lock", {31'h0, config_write_lock_out}, 32'h1);
    wb(1'b1, IMCL_OFS_CTRL, 32'h0);
    wb(1'b1, IMCL_OFS_THRESH, 32'h0);
    wb(1'b0, IMCL_OFS_CTRL, 32'h0);
    chk("ctrl", q, 32'h3);
    wb(1'b0, IMCL_OFS_THRESH, 32'h0);
    chk("thresh", q, 32'h0f03);
    wb(1'b0, IMCL_OFS_IRQ_STAT, 32'h0);
    chk("irq_stat", q & 32'h4, 32'h4);
    // A lock-register write with the clear bit set is not a setting change.
    wb(1'b1, IMCL_OFS_IRQ_STAT, 32'h4);
    wb(1'b1, IMCL_OFS_LOCK, 32'h4);
    wb(1'b0, IMCL_OFS_IRQ_STAT, 32'h0);
    chk("irq_stat", q & 32'h4, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    rst(2'h0);
    repeat (4) @(posedge clk_in);
    chk("lock", {31'h0, config_write_lock_out}, 32'h0);
    chk("spoof", {31'h0, spoof_detect_out}, 32'h0);
    wb(1'b1, IMCL_OFS_LOCK, 32'h2);
    rst(2'h2);
    chk("lock_store", {31'h0, lock_store_out}, 32'h1);
    store_clear_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    chk("lock_store", {31'h0, lock_store_out}, 32'h0);
    store_clear_in <= 1'b0;
    give_verdict();
  end
endmodule
